// file: core/psrc_top.sv
/*
 * pll setup and reset cause registers: reset cause flags kept across
 * system resets, pll multiplier, reference divider and post divider
 * settings, and the frequency ratios derived from them.
 * assumes reset cause and analog status inputs come from other clock
 * domains, and a plain register port driven on mclk_in.
 */
// Chosen here: the address-and-strobe port.
// Summary of operation
// - power-on reset sets power_on_reset_flag
// - low voltage or power-on sets its flag
// - watchdog reset sets flag; power-on clears
// - oscillator monitor reset sets flag; power-on clears
// - pll monitor reset sets flag; power-on clears
// - flags clear only by writing one or by power-on reset
// - multiplier writable only unprotected with pll selected
// - multiplier write clears settled and qualified status
// - reference divider gated likewise; write clears status
// - vco ratio is two times (factor+1)
// - vco range code stored for pll gain
// - reference divided by divide+1 or internal
// - reference range code sets pll filter
// - internal reference forces filter to lowest range
// - post divider writable whenever pll selected
// - pll ratio divide+1 locked, else four
// - bus ratio is twice the pll ratio
// - post divider ramps within 32 cycles
// - every settled status change sets change flag
`timescale 1ns/10ps
`default_nettype none

module psrc_top #(
    parameter int SETTLE_COUNT = psrc_pkg::SETTLE_CYCLES
) (
    // clock and resets
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic por_rstn_in,
    // reset causes, levels from the reset controller
    input wire logic low_voltage_in,
    input wire logic watchdog_in,
    input wire logic osc_monitor_in,
    input wire logic pll_monitor_in,
    // analog status
    input wire logic pll_lock_in,
    input wire logic osc_good_in,
    // register port
    input wire logic [4:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    // pll settings
    output logic [7:0] vco_mult_out,
    output logic [1:0] vco_range_out,
    output logic [4:0] ref_div_out,
    output logic ref_from_osc_out,
    output logic [1:0] filter_range_out,
    output logic [5:0] pll_div_out,
    output logic [6:0] bus_div_out,
    output logic pll_settled_out
);

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic logic wr_hit(input logic [4:0] a, input logic [4:0] ofs, input logic w);
        wr_hit = w && (a == ofs);
    endfunction

    function automatic logic [5:0] plus_one(input logic [4:0] v);
        plus_one = {1'b0, v} + 6'h01;
    endfunction

    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    logic [3:0] cause_sync;
    logic [1:0] stat_sync;
    logic lvr_s, wdog_s, omon_s, pmon_s, lock_s, oscg_s;

    psrc_sync #(.WIDTH(4)) u_cause_sync (
        .mclk_in(mclk_in),
        .rstn_in(por_rstn_in),
        .async_in({low_voltage_in, watchdog_in, osc_monitor_in, pll_monitor_in}),
        .sync_out(cause_sync)
    );

    psrc_sync #(.WIDTH(2)) u_stat_sync (
        .mclk_in(mclk_in),
        .rstn_in(rstn_in),
        .async_in({pll_lock_in, osc_good_in}),
        .sync_out(stat_sync)
    );

    assign {lvr_s, wdog_s, omon_s, pmon_s} = cause_sync;
    assign {lock_s, oscg_s} = stat_sync;

    // ------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------
    logic [2:0] control_reg;
    logic write_protect, pll_clock_select, ext_osc_enable;
    logic synr_wr, ref_div_wr, post_wr, cause_wr, stat_wr, ctrl_wr;

    assign write_protect = control_reg[psrc_pkg::POS_WRITE_PROTECT];
    assign pll_clock_select = control_reg[psrc_pkg::POS_PLL_CLOCK_SELECT];
    assign ext_osc_enable = control_reg[psrc_pkg::POS_EXT_OSC_ENABLE];
    assign synr_wr = wr_hit(addr_in, psrc_pkg::OFS_SYNTH_MULT, wr_in)
        && !write_protect && pll_clock_select;
    assign ref_div_wr = wr_hit(addr_in, psrc_pkg::OFS_REF_DIVIDER, wr_in)
        && !write_protect && pll_clock_select;
    assign post_wr = wr_hit(addr_in, psrc_pkg::OFS_POST_DIVIDER, wr_in) && pll_clock_select;
    assign cause_wr = wr_hit(addr_in, psrc_pkg::OFS_RESET_CAUSE, wr_in);
    assign stat_wr = wr_hit(addr_in, psrc_pkg::OFS_SETTLE_STATUS, wr_in);
    assign ctrl_wr = wr_hit(addr_in, psrc_pkg::OFS_CLOCK_CONTROL, wr_in);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] cause_reg, synth_reg, ref_div_reg, post_reg;
    logic [7:0] cause_set, cause_clr;

    assign cause_set = {1'b0, 1'b0, lvr_s, 1'b0, wdog_s, 1'b0, omon_s, pmon_s};
    assign cause_clr = cause_wr ? (wdata_in & psrc_pkg::MASK_RESET_CAUSE) : 8'h00;

    // flags live on the power-on reset only, so system resets leave them
    always_ff @(posedge mclk_in or negedge por_rstn_in) begin
        if (!por_rstn_in) begin
            cause_reg <= psrc_pkg::RST_RESET_CAUSE;
        end else begin
            cause_reg <= (cause_reg & ~cause_clr) | cause_set;
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            control_reg <= psrc_pkg::RST_CLOCK_CONTROL;
        end else if (ctrl_wr) begin
            control_reg <= wdata_in[2:0];
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            synth_reg <= psrc_pkg::RST_SYNTH_MULT;
        end else if (synr_wr) begin
            synth_reg <= wdata_in & psrc_pkg::MASK_SYNTH_MULT;
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ref_div_reg <= psrc_pkg::RST_REF_DIVIDER;
        end else if (ref_div_wr) begin
            ref_div_reg <= wdata_in & psrc_pkg::MASK_REF_DIVIDER;
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            post_reg <= psrc_pkg::RST_POST_DIVIDER;
        end else if (post_wr) begin
            post_reg <= wdata_in & psrc_pkg::MASK_POST_DIVIDER;
        end
    end

    // ------------------------------------------------------------
    // settled and qualified status
    // ------------------------------------------------------------
    logic settled_reg, qualified_reg, change_reg;
    logic [7:0] settle_cnt_reg;
    logic status_clear;

    assign status_clear = synr_wr || ref_div_wr;

    // after a clear, a status returns with its input high once lock or oscillator good held for the settle count
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            settle_cnt_reg <= 8'h00;
        end else if (status_clear || (!lock_s && !oscg_s)) begin
            settle_cnt_reg <= 8'h00;
        end else if (settle_cnt_reg < 8'(SETTLE_COUNT)) begin
            settle_cnt_reg <= settle_cnt_reg + 8'h01;
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            settled_reg <= 1'b0;
            qualified_reg <= 1'b0;
        end else if (status_clear) begin
            settled_reg <= 1'b0;
            qualified_reg <= 1'b0;
        end else begin
            settled_reg <= lock_s && (settle_cnt_reg >= 8'(SETTLE_COUNT));
            qualified_reg <= oscg_s && (settle_cnt_reg >= 8'(SETTLE_COUNT));
        end
    end

    logic settled_next;
    assign settled_next = status_clear ? 1'b0 : (lock_s && (settle_cnt_reg >= 8'(SETTLE_COUNT)));

    // set wins over a software clear in the same cycle
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            change_reg <= 1'b0;
        end else if (settled_next != settled_reg) begin
            change_reg <= 1'b1;
        end else if (stat_wr && wdata_in[psrc_pkg::POS_SETTLE_CHANGE]) begin
            change_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // frequency relations
    // ------------------------------------------------------------
    logic [5:0] div_target;
    logic [5:0] div_applied;

    assign div_target = settled_reg ? plus_one(post_reg[4:0]) : psrc_pkg::UNLOCKED_DIVIDE;

    psrc_ramp #(.WIDTH(6)) u_ramp (
        .mclk_in(mclk_in),
        .rstn_in(rstn_in),
        .target_in(div_target),
        .ratio_out(div_applied)
    );

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            vco_mult_out <= 8'h02;
            vco_range_out <= 2'h0;
            ref_div_out <= 5'h01;
            ref_from_osc_out <= 1'b0;
            filter_range_out <= psrc_pkg::REF_RANGE_1_TO_2MHZ;
            pll_div_out <= psrc_pkg::UNLOCKED_DIVIDE;
            bus_div_out <= 7'h08;
            pll_settled_out <= 1'b0;
        end else begin
            vco_mult_out <= {7'({1'b0, synth_reg[5:0]} + 7'h01), 1'b0};
            vco_range_out <= synth_reg[psrc_pkg::VCO_RANGE_LSB +: 2];
            ref_div_out <= ext_osc_enable ? 5'(plus_one({1'b0, ref_div_reg[3:0]})) : 5'h01;
            ref_from_osc_out <= ext_osc_enable;
            filter_range_out <= ext_osc_enable ? ref_div_reg[psrc_pkg::REF_RANGE_LSB +: 2]
                : psrc_pkg::REF_RANGE_1_TO_2MHZ;
            pll_div_out <= div_applied;
            bus_div_out <= {div_applied, 1'b0};
            pll_settled_out <= settled_reg;
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    logic [7:0] rd_mux;

    always_comb begin
        rd_mux = 8'h00;
        unique case (addr_in)
            psrc_pkg::OFS_CLOCK_CONTROL: rd_mux = {5'h00, control_reg};
            psrc_pkg::OFS_SETTLE_STATUS: rd_mux = {3'h0, change_reg, settled_reg, 2'h0, qualified_reg};
            psrc_pkg::OFS_RESET_CAUSE: rd_mux = cause_reg & psrc_pkg::MASK_RESET_CAUSE;
            psrc_pkg::OFS_SYNTH_MULT: rd_mux = synth_reg;
            psrc_pkg::OFS_REF_DIVIDER: rd_mux = ref_div_reg & psrc_pkg::MASK_REF_DIVIDER;
            psrc_pkg::OFS_POST_DIVIDER: rd_mux = post_reg & psrc_pkg::MASK_POST_DIVIDER;
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_out <= 8'h00;
        end else begin
            rdata_out <= rd_in ? rd_mux : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in || !por_rstn_in);

    sequence s_synr_accept;
        wr_in && addr_in == psrc_pkg::OFS_SYNTH_MULT && !write_protect && pll_clock_select;
    endsequence

    sequence s_status_low;
        !settled_reg && !qualified_reg;
    endsequence

    sequence s_post_accept;
        wr_in && addr_in == psrc_pkg::OFS_POST_DIVIDER && pll_clock_select;
    endsequence

    chk_wdog_flag_set: assert property (wdog_s |=> cause_reg[psrc_pkg::POS_WATCHDOG])
        else $error("watchdog cause not latched");
    chk_pmon_flag_set: assert property (pmon_s |=> cause_reg[psrc_pkg::POS_PLL_MONITOR])
        else $error("pll monitor cause not latched");
    chk_flag_w1c: assert property ((cause_wr && wdata_in[psrc_pkg::POS_OSC_MONITOR] && !omon_s)
        |=> !cause_reg[psrc_pkg::POS_OSC_MONITOR])
        else $error("write one did not clear flag");
    chk_flag_zero_keep: assert property ((cause_wr && wdata_in == 8'h00 && cause_set == 8'h00)
        |=> $stable(cause_reg))
        else $error("write zero changed flags");
    chk_synr_protect: assert property ((wr_in && addr_in == psrc_pkg::OFS_SYNTH_MULT
        && (write_protect || !pll_clock_select)) |=> $stable(synth_reg))
        else $error("protected multiplier write took effect");
    chk_synr_clears: assert property (s_synr_accept |=> s_status_low ##1 (vco_mult_out
        == 8'(2 * ({2'b00, synth_reg[5:0]} + 8'h01))))
        else $error("multiplier write did not clear status or set ratio");
    chk_ref_div_gate: assert property ((wr_in && addr_in == psrc_pkg::OFS_REF_DIVIDER && write_protect)
        |=> $stable(ref_div_reg))
        else $error("protected reference divider write took effect");
    chk_post_gate: assert property ((wr_in && addr_in == psrc_pkg::OFS_POST_DIVIDER && !pll_clock_select)
        |=> $stable(post_reg))
        else $error("post divider write without pll select");
    chk_filter_fixed: assert property (!ext_osc_enable |=> filter_range_out == psrc_pkg::REF_RANGE_1_TO_2MHZ)
        else $error("filter range not fixed on internal reference");
    chk_ramp_step: assert property ((div_applied < div_target) |=> div_applied == $past(div_applied) + 6'h01)
        else $error("post divider ramp did not step");
    chk_bus_ratio: assert property (bus_div_out == {pll_div_out, 1'b0})
        else $error("bus ratio not twice pll ratio");
    chk_change_flag: assert property ((settled_next != settled_reg) |=> change_reg)
        else $error("settled change did not set flag");
    chk_lvr_flag_set: assert property (lvr_s |=> cause_reg[psrc_pkg::POS_LOW_VOLTAGE])
        else $error("low voltage cause not latched");
    chk_omon_flag_set: assert property (omon_s |=> cause_reg[psrc_pkg::POS_OSC_MONITOR])
        else $error("oscillator monitor cause not latched");
    chk_post_accept: assert property (s_post_accept
        |=> post_reg == ($past(wdata_in) & psrc_pkg::MASK_POST_DIVIDER))
        else $error("accepted post divider write lost");
    chk_ramp_down: assert property ((div_applied > div_target) |=> div_applied == $past(div_applied) - 6'h01)
        else $error("post divider ramp did not step down");
    chk_reserved_read: assert property ((rd_in && addr_in == 5'h1F) |=> rdata_out == 8'h00)
        else $error("reserved offset read not zero");
    chk_change_clear: assert property ((stat_wr && wdata_in[psrc_pkg::POS_SETTLE_CHANGE]
        && settled_next == settled_reg) |=> !change_reg)
        else $error("change flag not cleared by write one");
    chk_ref_internal: assert property (!ext_osc_enable |=> ref_div_out == 5'h01 && !ref_from_osc_out)
        else $error("internal reference ratio not one");
    chk_unlocked_hold: assert property ((!settled_reg && div_applied == psrc_pkg::UNLOCKED_DIVIDE)
        |=> div_applied == psrc_pkg::UNLOCKED_DIVIDE)
        else $error("unlocked ratio left four");

endmodule

`default_nettype wire

// file: core/psrc_pkg.sv
/*
 * constants of the pll setup and reset cause block: register offsets,
 * field positions, reset values and timing counts.
 * assumes a plain register port with 8-bit data and a 10 MHz bus clock.
 */
package psrc_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [4:0] OFS_CLOCK_CONTROL = 5'h00;
    localparam logic [4:0] OFS_SETTLE_STATUS = 5'h01;
    localparam logic [4:0] OFS_RESET_CAUSE = 5'h03;
    localparam logic [4:0] OFS_SYNTH_MULT = 5'h04;
    localparam logic [4:0] OFS_REF_DIVIDER = 5'h05;
    localparam logic [4:0] OFS_POST_DIVIDER = 5'h06;

    // ------------------------------------------------------------
    // reset cause flag positions
    // ------------------------------------------------------------
    localparam int POS_POWER_ON = 6;
    localparam int POS_LOW_VOLTAGE = 5;
    localparam int POS_WATCHDOG = 3;
    localparam int POS_OSC_MONITOR = 1;
    localparam int POS_PLL_MONITOR = 0;
    localparam logic [7:0] MASK_RESET_CAUSE = 8'h6B;

    // ------------------------------------------------------------
    // own control and status positions
    // ------------------------------------------------------------
    localparam int POS_WRITE_PROTECT = 0;
    localparam int POS_PLL_CLOCK_SELECT = 1;
    localparam int POS_EXT_OSC_ENABLE = 2;
    localparam int POS_SETTLE_CHANGE = 4;
    localparam int POS_PLL_SETTLED = 3;
    localparam int POS_OSC_QUALIFIED = 0;

    // ------------------------------------------------------------
    // field layouts
    // ------------------------------------------------------------
    localparam int VCO_RANGE_LSB = 6;
    localparam int REF_RANGE_LSB = 6;
    localparam logic [7:0] MASK_SYNTH_MULT = 8'hFF;
    localparam logic [7:0] MASK_REF_DIVIDER = 8'hCF;
    localparam logic [7:0] MASK_POST_DIVIDER = 8'h1F;
    localparam logic [1:0] REF_RANGE_1_TO_2MHZ = 2'h0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_RESET_CAUSE = 8'h60;
    localparam logic [7:0] RST_SYNTH_MULT = 8'h00;
    localparam logic [7:0] RST_REF_DIVIDER = 8'h00;
    localparam logic [7:0] RST_POST_DIVIDER = 8'h00;
    localparam logic [2:0] RST_CLOCK_CONTROL = 3'h0;

    // ------------------------------------------------------------
    // frequency relations and timing
    // ------------------------------------------------------------
    localparam logic [5:0] UNLOCKED_DIVIDE = 6'h04;
    localparam int RAMP_MAX_CYCLES = 32;
    localparam int CLOCK_PERIOD_NS = 100;
    localparam int SETTLE_TIME_NS = 1000;
    localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

endpackage

// file: core/psrc_sync.sv
/*
 * two flip-flop synchroniser for a group of independent levels.
 * assumes each bit may change at any time relative to mclk_in.
 */
`timescale 1ns/10ps
`default_nettype none

module psrc_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rstn_in,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage_reg;

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            stage_reg <= '0;
            sync_out <= '0;
        end else begin
            stage_reg <= async_in;
            sync_out <= stage_reg;
        end
    end

endmodule

`default_nettype wire

// file: core/psrc_ramp.sv
/*
 * post divider ramp: moves the applied divide ratio by one step per
 * clock toward the target ratio, so the output frequency never jumps.
 * assumes the target lies between 1 and 32.
 */
`timescale 1ns/10ps
`default_nettype none

module psrc_ramp #(
    parameter int WIDTH = 6
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rstn_in,
    // ratio
    input wire logic [WIDTH-1:0] target_in,
    output logic [WIDTH-1:0] ratio_out
);

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ratio_out <= WIDTH'(psrc_pkg::UNLOCKED_DIVIDE);
        end else if (ratio_out < target_in) begin
            ratio_out <= ratio_out + WIDTH'(1);
        end else if (ratio_out > target_in) begin
            ratio_out <= ratio_out - WIDTH'(1);
        end
    end

endmodule

`default_nettype wire

// file: tb/psrc_top_test.sv
/*
 * self-checking bench of psrc_top: register image model, reset cause
 * flags, write gating, frequency ratios, settle status and ramp.
 * assumes psrc_pkg is compiled first; assertions live in the design.
 */
`timescale 1ns/10ps
`default_nettype none

module psrc_top_test;
    logic mclk_in, rstn_in, por_rstn_in, low_voltage_in, watchdog_in;
    logic osc_monitor_in, pll_monitor_in, pll_lock_in, osc_good_in, wr_in, rd_in;
    logic [4:0] addr_in;
    logic [7:0] wdata_in, rdata_out, vco_mult_out, v;
    logic [1:0] vco_range_out, filter_range_out;
    logic [4:0] ref_div_out;
    logic ref_from_osc_out, pll_settled_out;
    logic [5:0] pll_div_out;
    logic [6:0] bus_div_out;
    int errors, compares, exp_flags, m_syn, m_ref, m_post;
    int flag_bits[4] = '{8'h20, 8'h08, 8'h02, 8'h01};

    psrc_top #(.SETTLE_COUNT(8)) dut (
        .mclk_in(mclk_in), .rstn_in(rstn_in), .por_rstn_in(por_rstn_in),
        .low_voltage_in(low_voltage_in), .watchdog_in(watchdog_in),
        .osc_monitor_in(osc_monitor_in), .pll_monitor_in(pll_monitor_in),
        .pll_lock_in(pll_lock_in), .osc_good_in(osc_good_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .vco_mult_out(vco_mult_out), .vco_range_out(vco_range_out), .ref_div_out(ref_div_out),
        .ref_from_osc_out(ref_from_osc_out), .filter_range_out(filter_range_out),
        .pll_div_out(pll_div_out), .bus_div_out(bus_div_out), .pll_settled_out(pll_settled_out)
    );

    // ------------------------------------------------------------
    // clock and tasks
    // ------------------------------------------------------------
    initial begin
        mclk_in = 1'b0;
        forever #50 mclk_in = ~mclk_in;
    end

    task test_done;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge mclk_in);
        wr_in <= 1'b0;
    endtask

    task rdchk(input logic [4:0] a, input logic [7:0] exp);
        @(posedge mclk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        #1;
        chk(rdata_out, exp);
    endtask

    task settle_out;
        repeat (2) @(posedge mclk_in);
        #1;
    endtask

    task do_reset(input logic por);
        @(posedge mclk_in);
        rstn_in <= 1'b0;
        por_rstn_in <= ~por;
        repeat (3) @(posedge mclk_in);
        rstn_in <= 1'b1;
        por_rstn_in <= 1'b1;
        m_syn = 0;
        m_ref = 0;
        m_post = 0;
    endtask

    task wait_out(input logic sel, input logic [5:0] val, input int bound);
        int n;
        n = 0;
        while (n < bound && (sel ? pll_div_out !== val : pll_settled_out !== val[0])) begin
            @(posedge mclk_in);
            #1;
            n++;
        end
        compares++;
        if (n >= bound) begin
            errors++;
            $display("unexpected at %0t: wait for %h ran out", $time, val);
            test_done;
        end
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {rstn_in, por_rstn_in, low_voltage_in, watchdog_in, osc_monitor_in} = 5'h00;
        {pll_monitor_in, pll_lock_in, osc_good_in, wr_in, rd_in} = 5'h00;
        addr_in = 5'h00;
        wdata_in = 8'h00;
        errors = 0;
        compares = 0;
        void'($urandom(32'hf2ac));
        do_reset(1'b1);
        exp_flags = 8'h60;
        rdchk(psrc_pkg::OFS_RESET_CAUSE, exp_flags[7:0]);
        rdchk(5'h1F, 8'h00);
        wr(psrc_pkg::OFS_RESET_CAUSE, 8'h60);
        exp_flags = 0;
        rdchk(psrc_pkg::OFS_RESET_CAUSE, 8'h00);
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk_in);
            {low_voltage_in, watchdog_in, osc_monitor_in, pll_monitor_in} <= 4'h8 >> i;
            repeat (3) @(posedge mclk_in);
            {low_voltage_in, watchdog_in, osc_monitor_in, pll_monitor_in} <= 4'h0;
            repeat (4) @(posedge mclk_in);
            exp_flags |= flag_bits[i];
            rdchk(psrc_pkg::OFS_RESET_CAUSE, exp_flags[7:0]);
        end
        wr(psrc_pkg::OFS_RESET_CAUSE, 8'h94);
        rdchk(psrc_pkg::OFS_RESET_CAUSE, exp_flags[7:0]);
        wr(psrc_pkg::OFS_RESET_CAUSE, 8'h00);
        rdchk(psrc_pkg::OFS_RESET_CAUSE, exp_flags[7:0]);
        wr(psrc_pkg::OFS_RESET_CAUSE, 8'h0A);
        exp_flags &= 8'hF5;
        rdchk(psrc_pkg::OFS_RESET_CAUSE, exp_flags[7:0]);
        do_reset(1'b0);
        rdchk(psrc_pkg::OFS_RESET_CAUSE, exp_flags[7:0]);
        do_reset(1'b1);
        rdchk(psrc_pkg::OFS_RESET_CAUSE, 8'h60);
        // write gating over protect and select combinations
        for (int c = 0; c < 4; c++) begin
            wr(psrc_pkg::OFS_CLOCK_CONTROL, 8'(c));
            v = 8'($urandom);
            wr(psrc_pkg::OFS_SYNTH_MULT, v);
            wr(psrc_pkg::OFS_REF_DIVIDER, v);
            wr(psrc_pkg::OFS_POST_DIVIDER, v);
            if (c == 2) begin
                m_syn = v;
                m_ref = v & 8'hCF;
            end
            if (c >= 2)
                m_post = v & 8'h1F;
            rdchk(psrc_pkg::OFS_SYNTH_MULT, m_syn[7:0]);
            rdchk(psrc_pkg::OFS_REF_DIVIDER, m_ref[7:0]);
            rdchk(psrc_pkg::OFS_POST_DIVIDER, m_post[7:0]);
        end
        // multiplier, vco range and internal reference
        wr(psrc_pkg::OFS_CLOCK_CONTROL, 8'h02);
        for (int i = 0; i < 4; i++) begin
            v = {2'(i), 6'($urandom)};
            wr(psrc_pkg::OFS_SYNTH_MULT, v);
            wr(psrc_pkg::OFS_REF_DIVIDER, 8'($urandom));
            settle_out;
            chk(vco_mult_out, 8'(2 * (v[5:0] + 1)));
            chk(8'(vco_range_out), 8'(v[7:6]));
            chk(8'(ref_div_out), 8'h01);
            chk(8'(filter_range_out), 8'h00);
        end
        // external reference: divider and filter range codes
        wr(psrc_pkg::OFS_CLOCK_CONTROL, 8'h06);
        for (int r = 0; r < 4; r++) begin
            v = {2'(r), 2'b00, 4'($urandom)};
            wr(psrc_pkg::OFS_REF_DIVIDER, v);
            settle_out;
            chk(8'(ref_div_out), 8'(v[3:0] + 1));
            chk(8'(filter_range_out), 8'(r));
            chk(8'(ref_from_osc_out), 8'h01);
        end
        // settle status, ratios and ramp
        wr(psrc_pkg::OFS_CLOCK_CONTROL, 8'h02);
        wr(psrc_pkg::OFS_POST_DIVIDER, 8'h05);
        settle_out;
        chk(8'(pll_div_out), 8'h04);
        @(posedge mclk_in);
        pll_lock_in <= 1'b1;
        osc_good_in <= 1'b1;
        wait_out(1'b0, 6'h01, 40);
        wait_out(1'b1, 6'h06, 36);
        chk(8'(bus_div_out), 8'h0C);
        wr(psrc_pkg::OFS_POST_DIVIDER, 8'h1F);
        wait_out(1'b1, 6'h20, 35);
        chk(8'(bus_div_out), 8'h40);
        wr(psrc_pkg::OFS_SETTLE_STATUS, 8'h10);
        rdchk(psrc_pkg::OFS_SETTLE_STATUS, 8'h09);
        wr(psrc_pkg::OFS_SYNTH_MULT, 8'h01);
        rdchk(psrc_pkg::OFS_SETTLE_STATUS, 8'h10);
        chk(8'(pll_settled_out), 8'h00);
        wait_out(1'b0, 6'h01, 40);
        wait_out(1'b1, 6'h20, 40);
        @(posedge mclk_in);
        pll_lock_in <= 1'b0;
        wait_out(1'b0, 6'h00, 10);
        wait_out(1'b1, 6'h04, 36);
        chk(8'(bus_div_out), 8'h08);
        test_done;
    end
endmodule

`default_nettype wire
